// ### common/sts_pkg.sv
package sts_pkg;

  // Sequence geometry
  localparam int          SEQ_LEVELS     = 8;
  localparam int          LVL_W          = 3;
  localparam int          LCNT_W         = 4;
  localparam int          OCC_W          = 16;
  localparam logic [3:0]  MIN_LEVELS     = 4'h2;
  localparam logic [3:0]  MAX_LEVELS     = 4'h8;
  localparam logic [15:0] OCC_MIN        = 16'h0001;

  // Acquisition memory and data path
  localparam int          SAMPLE_W_DEF   = 16;
  localparam int          ACQ_DEPTH_DEF  = 1024;
  localparam int          FIFO_DEPTH_DEF = 8;

  // Values after reset
  localparam logic [2:0]  LEVEL_RST      = 3'h0;
  localparam logic [15:0] OCC_RST        = 16'h0000;
  localparam logic [2:0]  TRIG_LVL_DEF   = 3'h0;

  // Branch modes
  typedef enum logic [1:0] {
    STS_BR_OFF       = 2'h0,
    STS_BR_RESTART   = 2'h1,
    STS_BR_PER_LEVEL = 2'h2
  } sts_branch_t;

  // Arm sources
  typedef enum logic [1:0] {
    STS_ARM_RUN   = 2'h0,
    STS_ARM_EXT   = 2'h1,
    STS_ARM_OTHER = 2'h2
  } sts_arm_t;

endpackage

// ### src/sts_fifo.sv
`timescale 1ns/1ps
module sts_fifo
  import sts_pkg::*;
#(
  parameter int WIDTH = SAMPLE_W_DEF,
  parameter int DEPTH = FIFO_DEPTH_DEF
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             rstn,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("sts_fifo: DEPTH must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [AW:0]      next_count;
  logic             next_in_ready;
  logic             next_out_valid;
  logic             do_wr;
  logic             do_rd;
  logic [WIDTH-1:0] next_out_data;

  always_comb begin
    do_wr          = in_valid && in_ready;
    do_rd          = out_valid && out_ready;
    next_wr_ptr    = do_wr ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr    = do_rd ? rd_ptr + 1'b1 : rd_ptr;
    // Head kept in a flop; a word written as the new head bypasses memory
    if (do_wr && wr_ptr == next_rd_ptr) begin
      next_out_data = in_data;
    end else begin
      next_out_data = mem[next_rd_ptr];
    end
    next_count     = count;
    if (do_wr && !do_rd) begin
      next_count = count + 1'b1;
    end else if (do_rd && !do_wr) begin
      next_count = count - 1'b1;
    end
    // Flags registered so both ports come straight from flops
    next_in_ready  = next_count != (AW+1)'(DEPTH);
    next_out_valid = next_count != '0;
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      count     <= '0;
      in_ready  <= 1'b0;
      out_valid <= 1'b0;
      out_data  <= '0;
    end else begin
      wr_ptr    <= next_wr_ptr;
      rd_ptr    <= next_rd_ptr;
      count     <= next_count;
      in_ready  <= next_in_ready;
      out_valid <= next_out_valid;
      out_data  <= next_out_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (do_wr) begin
      mem[wr_ptr] <= in_data;
    end
  end

endmodule

// ### src/sts_sequencer.sv
// Function
// - Trigger and store levels always kept
// - Store states matching level's store qualifier, plus the trigger state
// - Primary branch advances, or triggers in trigger level
// - Primary needs programmed 1..65535 occurrences
// - Secondary qualifier jumps to its target level
// - Macro only in next-to-last level, merges last
// - Macro stores level qualifier, then macro qualifier
// - Macro loops after disable until memory full
// - Trigger state always stored
// - Arm from run, external, or other analyzer
// - Branch mode off drops all secondary branches
// - Restart: failed primary plus restart returns level 1, only before the trigger
// - Two to eight levels configured
// - Secondary branches never cross trigger level
// - One secondary target per level
`timescale 1ns/1ps
module sts_sequencer
  import sts_pkg::*;
#(
  parameter int SAMPLE_W   = SAMPLE_W_DEF,
  parameter int ACQ_DEPTH  = ACQ_DEPTH_DEF,
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
  // Clock and reset
  input  wire logic                        core_clk,
  input  wire logic                        rstn,
  // Run control and arming
  input  wire logic                        run,
  input  wire logic [1:0]                  arm_source_select,
  input  wire logic                        ext_arm_in,
  input  wire logic                        other_arm_in,
  input  wire logic                        other_on,
  input  wire logic                        other_arm_source_select_this,
  // Sequence configuration
  input  wire logic [LCNT_W-1:0]           level_count,
  input  wire logic [LVL_W-1:0]            trigger_level,
  input  wire logic [SEQ_LEVELS*OCC_W-1:0] occurrence_count,
  input  wire logic [1:0]                  branch_mode,
  input  wire logic [SEQ_LEVELS-1:0]       branch_enable,
  input  wire logic [SEQ_LEVELS*LVL_W-1:0] branch_target,
  input  wire logic                        macro_on,
  // Acquired state and qualifier matches
  input  wire logic                        sample_valid,
  output logic                             sample_ready,
  input  wire logic [SAMPLE_W-1:0]         sample_data,
  input  wire logic [SEQ_LEVELS-1:0]       store_match,
  input  wire logic [SEQ_LEVELS-1:0]       primary_match,
  input  wire logic [SEQ_LEVELS-1:0]       secondary_match,
  input  wire logic                        restart_match,
  input  wire logic                        macro_enable_match,
  input  wire logic                        macro_store_match,
  input  wire logic                        macro_disable_match,
  // Acquisition memory stream
  output logic                             mem_valid,
  input  wire logic                        mem_ready,
  output logic [SAMPLE_W-1:0]              mem_data,
  // Status
  output logic                             armed,
  output logic                             triggered,
  output logic                             acq_done,
  output logic [LVL_W-1:0]                 seq_level,
  output logic [$clog2(ACQ_DEPTH+1)-1:0]   stored_count
);

  localparam int CNT_W = $clog2(ACQ_DEPTH+1);

  if (ACQ_DEPTH < 1 || SAMPLE_W < 1) begin : g_bad_param
    $error("sts_sequencer: ACQ_DEPTH and SAMPLE_W must be positive");
  end

  // Buffer pointers wrap, so its depth must be a power of two
  if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_bad_fifo
    $error("sts_sequencer: FIFO_DEPTH must be a power of two, at least 2");
  end

  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DONE} sts_state_t;

  sts_state_t       state;
  sts_state_t       next_state;
  // One shared occurrence counter, cleared on every level change
  logic [OCC_W-1:0] occ;
  logic [OCC_W-1:0] next_occ;
  logic [LVL_W-1:0] next_level;
  logic             macro_act;
  logic             next_macro_act;
  logic             next_triggered;
  logic             next_armed;
  logic             next_done;
  logic [CNT_W-1:0] next_stored;
  logic             ext_sync1;
  logic             ext_sync2;
  logic             other_sync1;
  logic             other_sync2;
  logic             next_ext_sync1;
  logic             next_other_sync1;

  // Effective configuration
  logic [LCNT_W-1:0] eff_levels;
  logic [LVL_W-1:0]  last_lvl;
  logic [LVL_W-1:0]  trig_lvl;
  logic              macro_ok;
  logic              arm_hit;

  // Per-sample decisions
  logic             take;
  logic             is_trig;
  logic             is_last;
  logic             is_macro;
  logic             prim;
  logic             hit;
  logic             sec_ok;
  logic             store;
  logic             push;
  logic [LVL_W-1:0] tgt;
  logic [OCC_W-1:0] occ_tgt;

  // Two-flop synchronisers for pins from outside this clock
  always_comb begin
    next_ext_sync1   = ext_arm_in;
    next_other_sync1 = other_arm_in;
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      ext_sync1   <= 1'b0;
      ext_sync2   <= 1'b0;
      other_sync1 <= 1'b0;
      other_sync2 <= 1'b0;
    end else begin
      ext_sync1   <= next_ext_sync1;
      ext_sync2   <= ext_sync1;
      other_sync1 <= next_other_sync1;
      other_sync2 <= other_sync1;
    end
  end

  always_comb begin
    if (level_count < MIN_LEVELS) begin
      eff_levels = MIN_LEVELS;
    end else if (level_count > MAX_LEVELS) begin
      eff_levels = MAX_LEVELS;
    end else begin
      eff_levels = level_count;
    end
    last_lvl = LVL_W'(eff_levels - 4'h1);
    // trigger level falls back to default, keeping a store level after it
    if ({1'b0, trigger_level} + 4'h2 <= eff_levels) begin
      trig_lvl = trigger_level;
    end else begin
      trig_lvl = TRIG_LVL_DEF;
    end
    // macro only when next-to-last level follows the trigger
    macro_ok = macro_on && ({1'b0, trig_lvl} + 4'h3 <= eff_levels);
    // other analyzer unusable when off or arm_source_select us
    unique case (arm_source_select)
      STS_ARM_EXT:   arm_hit = ext_sync2;
      STS_ARM_OTHER: arm_hit = (other_on && !other_arm_source_select_this) ? other_sync2 : 1'b1;
      default:       arm_hit = 1'b1;
    endcase
  end

  always_comb begin
    // Back-pressure: a state is only consumed when the buffer can take it
    take     = sample_valid && sample_ready;
    is_trig  = seq_level == trig_lvl;
    // Last level only stores, but may still take a secondary branch
    is_last  = seq_level == last_lvl;
    is_macro = macro_ok && (seq_level == last_lvl - 1'b1);
    tgt      = branch_target[seq_level*LVL_W +: LVL_W];
    occ_tgt  = occurrence_count[seq_level*OCC_W +: OCC_W];
    if (occ_tgt < OCC_MIN) begin
      occ_tgt = OCC_MIN;
    end
    // last level has no primary branch
    prim     = primary_match[seq_level] && !is_last && !is_macro;
    hit      = prim && ({1'b0, occ} + 17'h00001 >= {1'b0, occ_tgt});
    // Out-of-range targets are ignored rather than wrapped
    // single target, same side of trigger, per-level mode only
    sec_ok   = (branch_mode == STS_BR_PER_LEVEL) && branch_enable[seq_level] &&
               secondary_match[seq_level] && !is_macro && ({1'b0, tgt} < eff_levels) &&
               ((tgt <= trig_lvl) == (seq_level <= trig_lvl));
  end

  always_comb begin
    next_state     = state;
    next_level     = seq_level;
    next_occ       = occ;
    next_macro_act = macro_act;
    next_triggered = triggered;
    next_stored    = stored_count;
    store          = 1'b0;
    unique case (state)
      ST_IDLE: begin
        // wait for arm, then start at level 1
        if (run && arm_hit) begin
          next_state     = ST_RUN;
          next_level     = LEVEL_RST;
          next_occ       = OCC_RST;
          next_macro_act = 1'b0;
          next_triggered = 1'b0;
          next_stored    = '0;
        end
      end
      ST_RUN: begin
        // Dropping run aborts; words already queued still drain
        if (!run) begin
          next_state = ST_IDLE;
        end else if (take) begin
          if (is_macro) begin
            // Macro level never advances; only a full memory ends it
            // store per phase of the macro
            store = macro_act ? macro_store_match : store_match[seq_level];
            if (!macro_act && macro_enable_match) begin
              next_macro_act = 1'b1;
            end else if (macro_act && macro_disable_match) begin
              next_macro_act = 1'b0;
            end
          end else begin
            // level store qualifier, trigger state forced in
            store = store_match[seq_level] || (is_trig && hit);
            if (hit) begin
              next_occ   = OCC_RST;
              next_level = seq_level + 1'b1;
              if (is_trig) begin
                next_triggered = 1'b1;
              end
            end else if (sec_ok) begin
              next_occ   = OCC_RST;
              next_level = tgt;
            end else if (branch_mode == STS_BR_RESTART && restart_match && !prim && !triggered) begin
              // back to level 1 on a state failing the primary
              // Ignored after the trigger so post-trigger data is not cut short
              next_occ   = OCC_RST;
              next_level = LEVEL_RST;
            end else if (prim) begin
              next_occ = occ + 1'b1;
            end
          end
          if (store) begin
            next_stored = stored_count + 1'b1;
            if (stored_count + 1'b1 == CNT_W'(ACQ_DEPTH)) begin
              next_state = ST_DONE;
            end
          end
        end
      end
      ST_DONE: begin
        // Results held until run drops
        if (!run) begin
          next_state = ST_IDLE;
        end
      end
    endcase
    // Status follows the next state so each output leaves a flop
    push       = store;
    next_armed = next_state == ST_RUN;
    next_done  = next_state == ST_DONE;
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      state        <= ST_IDLE;
      seq_level    <= LEVEL_RST;
      occ          <= OCC_RST;
      macro_act    <= 1'b0;
      triggered    <= 1'b0;
      armed        <= 1'b0;
      acq_done     <= 1'b0;
      stored_count <= '0;
    end else begin
      state        <= next_state;
      seq_level    <= next_level;
      occ          <= next_occ;
      macro_act    <= next_macro_act;
      triggered    <= next_triggered;
      armed        <= next_armed;
      acq_done     <= next_done;
      stored_count <= next_stored;
    end
  end

  // Stored states queue toward acquisition memory
  sts_fifo #(
    .WIDTH (SAMPLE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .rstn      (rstn),
    .in_valid  (push),
    .in_ready  (sample_ready),
    .in_data   (sample_data),
    .out_valid (mem_valid),
    .out_ready (mem_ready),
    .out_data  (mem_data)
  );

endmodule

// ### bench/sts_checker.sv
`timescale 1ns/1ps
module sts_checker
  import sts_pkg::*;
#(
  parameter int ACQ_DEPTH = ACQ_DEPTH_DEF
) (
  // Clock, reset and arming
  input  wire logic                           core_clk,
  input  wire logic                           rstn,
  input  wire logic                           run,
  input  wire logic [1:0]                     arm_source_select,
  // Configuration
  input  wire logic [LCNT_W-1:0]              level_count,
  input  wire logic [LVL_W-1:0]               trigger_level,
  input  wire logic [SEQ_LEVELS*OCC_W-1:0]    occurrence_count,
  input  wire logic [1:0]                     branch_mode,
  input  wire logic [SEQ_LEVELS-1:0]          branch_enable,
  input  wire logic [SEQ_LEVELS*LVL_W-1:0]    branch_target,
  // State stream and status
  input  wire logic                           sample_valid,
  input  wire logic                           sample_ready,
  input  wire logic [SEQ_LEVELS-1:0]          store_match,
  input  wire logic [SEQ_LEVELS-1:0]          primary_match,
  input  wire logic [SEQ_LEVELS-1:0]          secondary_match,
  input  wire logic                           restart_match,
  input  wire logic                           armed,
  input  wire logic                           triggered,
  input  wire logic                           acq_done,
  input  wire logic [LVL_W-1:0]               seq_level,
  input  wire logic [$clog2(ACQ_DEPTH+1)-1:0] stored_count
);
  logic [LVL_W-1:0] br_to;
  logic             sm;
  logic             cfg_ok;
  assign br_to  = branch_target[seq_level*LVL_W+:LVL_W];
  assign sm     = store_match[seq_level];
  // Odd configurations are clamped or reverted, so only plain ones are judged
  assign cfg_ok = level_count >= MIN_LEVELS && level_count <= MAX_LEVELS && trigger_level + 4'h1 < level_count;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  sequence s_take; armed && run && sample_valid && sample_ready && !triggered && cfg_ok && seq_level <= trigger_level; endsequence
  sequence s_hit; s_take ##0 (primary_match[seq_level] && occurrence_count[seq_level*OCC_W+:OCC_W] <= OCC_MIN); endsequence
  property p_rst; $rose(rstn) |-> !armed && !triggered && !acq_done && !sample_ready ##1 sample_ready; endproperty
  a_rst: assert property (p_rst) else $error("state after reset wrong");
  property p_arm; !armed && !acq_done && run && arm_source_select == STS_ARM_RUN |=> armed && seq_level == LEVEL_RST && stored_count == '0 && !triggered; endproperty
  a_arm: assert property (p_arm) else $error("run did not arm at level 1");
  property p_hold; armed && run && !(sample_valid && sample_ready) |=> $stable(seq_level) && $stable(stored_count) && $stable(triggered); endproperty
  a_hold: assert property (p_hold) else $error("state changed without a sample");
  property p_trig; s_hit ##0 seq_level == trigger_level |=> triggered && stored_count == $past(stored_count) + 1'b1; endproperty
  a_trig: assert property (p_trig) else $error("trigger state not stored");
  property p_adv; s_hit ##0 seq_level < trigger_level |=> seq_level == $past(seq_level) + 3'h1 && !triggered; endproperty
  a_adv: assert property (p_adv) else $error("primary hit did not advance");
  property p_store; s_take ##0 !primary_match[seq_level] |=> stored_count - $past(stored_count) == $past(sm); endproperty
  a_store: assert property (p_store) else $error("store decision wrong");
  property p_sec; s_take ##0 (branch_mode == STS_BR_PER_LEVEL && !primary_match[seq_level] && secondary_match[seq_level]
    && branch_enable[seq_level] && br_to <= trigger_level) |=> seq_level == $past(br_to); endproperty
  a_sec: assert property (p_sec) else $error("secondary branch missed");
  property p_rest; s_take ##0 (branch_mode == STS_BR_RESTART && !primary_match[seq_level] && restart_match) |=> seq_level == LEVEL_RST; endproperty
  a_rest: assert property (p_rest) else $error("restart did not return");
  property p_done; acq_done |-> !armed && stored_count == ACQ_DEPTH; endproperty
  a_done: assert property (p_done) else $error("full memory not ending");
endmodule

bind sts_sequencer sts_checker #(.ACQ_DEPTH(ACQ_DEPTH)) u_checker (.*);

// ### bench/sts_target.sv
`timescale 1ns/1ps
module sts_target (
  // Clock and handshake
  input  wire logic   core_clk,
  input  wire logic   sample_ready,
  // Offered state
  output logic        sample_valid,
  output logic [15:0] sample_data,
  output logic [7:0]  store_match,
  output logic [7:0]  primary_match,
  output logic [7:0]  secondary_match,
  output logic        restart_match,
  output logic        macro_enable_match,
  output logic        macro_store_match,
  output logic        macro_disable_match
);
  initial {sample_valid, sample_data, store_match, primary_match, secondary_match, restart_match,
           macro_enable_match, macro_store_match, macro_disable_match} = '0;
  // Held until taken; released lines show the inverse so stale values cannot pass
  task automatic offer(input logic [15:0] d, input logic [7:0] st, input logic [7:0] pr, input logic [7:0] sc,
                       input logic [3:0] x);
    int n;
    n = 0;
    @(posedge core_clk);
    sample_valid <= 1'b1;
    {sample_data, store_match, primary_match, secondary_match} <= {d, st, pr, sc};
    {restart_match, macro_enable_match, macro_store_match, macro_disable_match} <= x;
    @(posedge core_clk);
    while (sample_ready !== 1'b1 && n < 40) begin
      n++;
      @(posedge core_clk);
    end
    sample_valid <= 1'b0;
    {sample_data, store_match, primary_match, secondary_match} <= ~{d, st, pr, sc};
    {restart_match, macro_enable_match, macro_store_match, macro_disable_match} <= ~x;
  endtask
endmodule

// ### bench/test_state_trigger_sequencer.sv
`timescale 1ns/1ps
module test_state_trigger_sequencer;
  import sts_pkg::*;
  localparam int AD = 16;
  logic         core_clk = 1'b0;
  logic         rstn = 1'b0;
  logic         run = 1'b0;
  logic         ext_arm_in = 1'b0;
  logic         other_arm_in = 1'b0;
  logic         other_on = 1'b0;
  logic         other_arm_source_select_this = 1'b0;
  logic         macro_on = 1'b0;
  logic         mem_ready = 1'b1;
  logic [1:0]   arm_source_select = 2'h0;
  logic [1:0]   branch_mode = 2'h0;
  logic [3:0]   level_count = 4'h2;
  logic [2:0]   trigger_level = 3'h0;
  // Level 2 jumps to level 3 on its secondary qualifier
  logic [7:0]   branch_enable = 8'h02;
  logic [23:0]  branch_target = 24'h000010;
  logic [127:0] occurrence_count = '0;
  logic         sample_valid, sample_ready, restart_match, macro_enable_match, macro_store_match;
  logic         macro_disable_match, mem_valid, armed, triggered, acq_done;
  logic [15:0]  sample_data, mem_data;
  logic [7:0]   store_match, primary_match, secondary_match;
  logic [2:0]   seq_level;
  logic [4:0]   stored_count;
  logic [15:0]  got_q[$];
  int           failures = 0;
  int           num_checks = 0;
  always #50 core_clk = ~core_clk;
  sts_sequencer #(.ACQ_DEPTH(AD)) dut (.*);
  sts_target tgt (.*);
  always @(posedge core_clk)
    if (mem_valid === 1'b1 && mem_ready === 1'b1) got_q.push_back(mem_data);
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic start(input logic [3:0] lc, input logic [2:0] tl, input logic [1:0] bm, input logic mo,
                       input logic [15:0] o0);
    @(posedge core_clk);
    run <= 1'b0;
    arm_source_select <= STS_ARM_RUN;
    {level_count, trigger_level, branch_mode, macro_on} <= {lc, tl, bm, mo};
    occurrence_count <= {112'h0, o0};
    @(posedge core_clk);
    run <= 1'b1;
    got_q.delete();
    repeat (2) @(posedge core_clk);
    check(armed, 1'b1);
  endtask
  task automatic t_arm;
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk);
      {run, ext_arm_in, other_arm_in} <= 3'h0;
      other_on <= (i != 2);
      other_arm_source_select_this <= (i == 3);
      arm_source_select <= (i == 0) ? STS_ARM_EXT : STS_ARM_OTHER;
      // Let the synchronisers flush the previous pass's arm level
      repeat (3) @(posedge core_clk);
      run <= 1'b1;
      repeat (6) @(posedge core_clk);
      check(armed, i >= 2);
      {ext_arm_in, other_arm_in} <= 2'h3;
      repeat (5) @(posedge core_clk);
      check(armed, 1'b1);
    end
  endtask
  task automatic t_trig;
    start(4'h3, 3'h1, STS_BR_OFF, 1'b0, 16'h0002);
    tgt.offer(16'hA001, 8'h01, 8'h01, 8'h00, 4'h0);
    tgt.offer(16'hA002, 8'h00, 8'h03, 8'h00, 4'h0);
    tgt.offer(16'hA003, 8'h00, 8'h02, 8'h00, 4'h0);
    tgt.offer(16'hA004, 8'h00, 8'h00, 8'h00, 4'h0);
    repeat (4) @(posedge core_clk);
    check(triggered, 1'b1);
    check(seq_level, 3'h2);
    check(got_q.size(), 2);
    check(got_q[1], 16'hA003);
  endtask
  task automatic t_clamp;
    // Level count and trigger out of range; no room for the macro
    start(4'h0, 3'h5, STS_BR_OFF, 1'b1, 16'h0000);
    tgt.offer(16'hE000, 8'h00, 8'h01, 8'h00, 4'h0);
    tgt.offer(16'hE001, 8'h00, 8'h02, 8'h00, 4'h0);
    repeat (2) @(posedge core_clk);
    check(triggered, 1'b1);
    check(seq_level, 3'h1);
    check(stored_count, 5'h1);
  endtask
  task automatic t_branch;
    logic [2:0] exp_lvl [4];
    exp_lvl = '{3'h1, 3'h0, 3'h2, 3'h1};
    for (int m = 0; m < 4; m++) begin
      start(4'h4, 3'h2, m[1:0], 1'b0, 16'h0000);
      tgt.offer(16'hC000, 8'h00, 8'h01, 8'h00, 4'h0);
      tgt.offer(16'hC001, 8'h00, 8'h00, 8'h02, 4'h8);
      repeat (2) @(posedge core_clk);
      check(seq_level, exp_lvl[m]);
    end
  endtask
  task automatic t_macro;
    start(4'h4, 3'h0, STS_BR_OFF, 1'b1, 16'h0000);
    tgt.offer(16'hB000, 8'h00, 8'h01, 8'h00, 4'h0);
    tgt.offer(16'hB001, 8'h00, 8'h02, 8'h00, 4'h0);
    tgt.offer(16'hB002, 8'h04, 8'h00, 8'h00, 4'h0);
    tgt.offer(16'hB003, 8'h00, 8'h00, 8'h00, 4'h4);
    tgt.offer(16'hB004, 8'h04, 8'h00, 8'h00, 4'h0);
    tgt.offer(16'hB005, 8'h00, 8'h00, 8'h00, 4'h2);
    tgt.offer(16'hB006, 8'h00, 8'h00, 8'h00, 4'h1);
    tgt.offer(16'hB007, 8'h04, 8'h00, 8'h00, 4'h0);
    repeat (3) @(posedge core_clk);
    check(stored_count, 5'h4);
    check(got_q[2], 16'hB005);
    check(got_q[3], 16'hB007);
    for (int i = 0; i < 12; i++)
      tgt.offer(16'hB100 + i[15:0], 8'h04, 8'h00, 8'h00, 4'h0);
    repeat (4) @(posedge core_clk);
    check(acq_done, 1'b1);
    check(armed, 1'b0);
    check(got_q.size(), AD);
  endtask
  task automatic t_fifo;
    start(4'h2, 3'h0, STS_BR_OFF, 1'b0, 16'h0000);
    mem_ready <= 1'b0;
    for (int i = 0; i < 8; i++)
      tgt.offer(16'hD000 + i[15:0], 8'h01, 8'h00, 8'h00, 4'h0);
    repeat (3) @(posedge core_clk);
    check(sample_ready, 1'b0);
    check(stored_count, 5'h8);
    mem_ready <= 1'b1;
    repeat (12) @(posedge core_clk);
    check(got_q.size(), 8);
    check(got_q[7], 16'hD007);
    check(sample_ready, 1'b1);
  endtask
  initial begin
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (2) @(posedge core_clk);
    check(armed, 1'b0);
    check(sample_ready, 1'b1);
    t_arm();
    t_trig();
    t_clamp();
    t_branch();
    t_macro();
    t_fifo();
    results();
  end
  initial begin
    repeat (4000) @(posedge core_clk);
    failures++;
    results();
  end
endmodule
